//--- logic/pot_host_pkg.sv
// constants, timing figures and carrier types for the wiper host controller
package pot_host_pkg;

	// clock period of core_clk_in in picoseconds (40 MHz)
	localparam int CLK_PERIOD_PS = 25000;

	// interface times, each in its own unit
	localparam int SEL_TO_STEP_NS            = 100;
	localparam int STROBE_HIGH_TO_DIR_CHANGE_NS = 100;
	localparam int DIR_TO_STEP_NS            = 2900;
	localparam int STEP_LOW_NS               = 1000;
	localparam int STEP_HIGH_NS              = 1000;
	localparam int STROBE_TO_DESELECT_GAP_NS = 1000;
	localparam int DESELECT_HOLD_TIME_STORE_MS  = 20;
	localparam int DESELECT_HOLD_TIME_NOSTORE_NS = 100;
	localparam int TAP_SETTLE_DELAY_US       = 100;
	localparam int POWER_UP_SETTLE_US        = 500;

	// least time in picoseconds to whole cycles, rounded up, at least one
	function automatic int cyc_ceil(input longint t_ps);
		longint c;
		c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		if (c < 1)
			c = 1;
		return int'(c);
	endfunction

	localparam int SEL_TO_STEP_CYC = cyc_ceil(SEL_TO_STEP_NS * 1000);
	localparam int DIR_CHANGE_CYC  =
		cyc_ceil(STROBE_HIGH_TO_DIR_CHANGE_NS * 1000);
	localparam int DIR_TO_STEP_CYC = cyc_ceil(DIR_TO_STEP_NS * 1000);
	localparam int STEP_LOW_CYC    = cyc_ceil(STEP_LOW_NS * 1000);
	localparam int STEP_HIGH_CYC   = cyc_ceil(STEP_HIGH_NS * 1000);
	localparam int STROBE_GAP_CYC  =
		cyc_ceil(STROBE_TO_DESELECT_GAP_NS * 1000);
	localparam int NOSTORE_HOLD_CYC =
		cyc_ceil(DESELECT_HOLD_TIME_NOSTORE_NS * 1000);
	localparam int TAP_SETTLE_CYC  =
		cyc_ceil(longint'(TAP_SETTLE_DELAY_US) * 1000000);
	localparam int STORE_HOLD_CYC  =
		cyc_ceil(longint'(DESELECT_HOLD_TIME_STORE_MS) * 1000000000);
	localparam int PWRUP_CYC       =
		cyc_ceil(longint'(POWER_UP_SETTLE_US) * 1000000);

	// select setup covers both select-to-strobe and direction setup
	localparam int SETUP_CYC = (SEL_TO_STEP_CYC > DIR_TO_STEP_CYC) ?
		SEL_TO_STEP_CYC : DIR_TO_STEP_CYC;
	// a no-save deselect also waits for the taps to settle
	localparam int NOSAVE_WAIT_CYC = (NOSTORE_HOLD_CYC > TAP_SETTLE_CYC) ?
		NOSTORE_HOLD_CYC : TAP_SETTLE_CYC;

	// wiper counter geometry
	localparam int POS_W     = 7;
	localparam int TIMER_W   = 20;
	localparam logic [POS_W-1:0] TAP_MAX  = 7'h63;
	localparam logic [POS_W-1:0] TAP_MIN  = 7'h00;
	localparam logic [POS_W-1:0] POS_ONE  = 7'h01;

	// one move request from the user side
	typedef struct packed {
		logic             dir_up;   // 1 moves toward the high end
		logic [POS_W-1:0] steps;    // number of strobe pulses
		logic             store;    // save position on deselect
		logic             keep_sel; // stay selected for more moves
	} move_cmd_t;

	// the three control pins toward the potentiometer
	typedef struct packed {
		logic select_n; // active-low chip select
		logic step_n;   // active-low step strobe
		logic dir_up;   // direction level
	} pot_pins_t;

	typedef enum logic [2:0] {
		ST_PWRUP,
		ST_IDLE,
		ST_SETUP,
		ST_LOW,
		ST_HIGH,
		ST_HOLD,
		ST_DESEL
	} host_state_t;

endpackage

//--- logic/cycle_timer.sv
// down-counting interval timer that flags expiry of a loaded count
`timescale 1ns/1ps
module cycle_timer
	import pot_host_pkg::*;
#(
	parameter int               W    = TIMER_W,
	parameter logic [W-1:0]     INIT = '0
) (
	input  wire logic         core_clk_in,
	input  wire logic         resetn_in,
	input  wire logic         load_in,    // one-cycle load strobe
	input  wire logic [W-1:0] count_in,   // cycles until expiry
	output logic              expired_out // level, high once elapsed
);

	logic [W-1:0] cnt_reg;     // remaining cycles
	logic [W-1:0] cnt_next;
	logic         expired_reg;
	logic         expired_next;

	// next count: a load wins, otherwise count down and stop at zero
	always_comb begin
		if (load_in)
			cnt_next = count_in;
		else if (cnt_reg != '0)
			cnt_next = cnt_reg - W'(1);
		else
			cnt_next = cnt_reg;
		expired_next = (cnt_next == '0);
	end

	// registers; INIT lets the power-up wait start straight from reset
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_reg     <= INIT;
			expired_reg <= (INIT == '0);
		end else begin
			cnt_reg     <= cnt_next;
			expired_reg <= expired_next;
		end
	end

	assign expired_out = expired_reg;

endmodule

//--- logic/pot_host_ctrl.sv
// host sequencer driving select, step strobe and direction of a digital pot
`timescale 1ns/1ps
module pot_host_ctrl
	import pot_host_pkg::*;
#(
	parameter int STORE_HOLD = STORE_HOLD_CYC, // cycles after a save
	parameter int PWRUP_WAIT = PWRUP_CYC       // cycles after reset
) (
	input  wire logic       core_clk_in,
	input  wire logic       resetn_in,
	input  wire logic       cmd_valid_in,
	input  wire move_cmd_t  cmd_in,
	output logic            cmd_ready_out,
	output logic            busy_out,
	output logic            done_out,
	output logic [POS_W-1:0] pos_out,
	output logic            pos_known_out,
	output pot_pins_t       pins_out
);

	// saturating one-tap move of the position model
	function automatic logic [POS_W-1:0] sat_step(
		input logic [POS_W-1:0] pos,
		input logic             up
	);
		logic [POS_W-1:0] r;
		r = pos;
		if (up && pos < TAP_MAX)
			r = pos + POS_ONE;
		else if (!up && pos > TAP_MIN)
			r = pos - POS_ONE;
		return r;
	endfunction

	host_state_t       state_reg, state_next;   // sequencer state
	pot_pins_t         pins_reg, pins_next;     // pin drivers
	move_cmd_t         cmd_reg, cmd_next;       // request in progress
	logic [POS_W-1:0]  left_reg, left_next;     // strobes still to give
	logic [POS_W-1:0]  pos_reg, pos_next;       // tap position model
	logic              known_reg, known_next;   // model matches device
	logic              ready_reg, ready_next;
	logic              busy_reg, busy_next;
	logic              done_reg, done_next;
	logic              tload;                   // timer load strobe
	logic [TIMER_W-1:0] tcount;                 // timer load value
	logic              texp;                    // interval elapsed

	// one shared timer paces every phase of the pin sequence
	cycle_timer #(
		.W    (TIMER_W),
		.INIT (TIMER_W'(PWRUP_WAIT))
	) u_timer (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.load_in     (tload),
		.count_in    (tcount),
		.expired_out (texp)
	);

	// next-state logic of the sequencer and its pins
	always_comb begin
		state_next = state_reg;
		pins_next  = pins_reg;
		cmd_next   = cmd_reg;
		left_next  = left_reg;
		pos_next   = pos_reg;
		known_next = known_reg;
		done_next  = 1'b0;
		tload      = 1'b0;
		tcount     = '0;
		case (state_reg)
			ST_PWRUP: begin
				// the device recalls its saved tap; stay off the pins
				if (texp)
					state_next = ST_IDLE;
			end
			ST_IDLE: begin
				// deselected, strobe high long enough to move direction
				if (cmd_valid_in) begin
					cmd_next = cmd_in;
					if (cmd_in.steps == TAP_MIN && !cmd_in.keep_sel) begin
						// nothing to do, selecting would only wear memory
						done_next = 1'b1;
					end else begin
						pins_next.dir_up   = cmd_in.dir_up;
						pins_next.select_n = 1'b0;
						left_next  = cmd_in.steps;
						tload      = 1'b1;
						tcount     = TIMER_W'(SETUP_CYC);
						state_next = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				// select and direction setup before the first strobe
				if (texp) begin
					if (left_reg == TAP_MIN) begin
						done_next  = 1'b1;
						state_next = ST_HOLD;
					end else begin
						pins_next.step_n = 1'b0;
						pos_next   = sat_step(pos_reg, pins_reg.dir_up);
						left_next  = left_reg - POS_ONE;
						tload      = 1'b1;
						tcount     = TIMER_W'(STEP_LOW_CYC);
						state_next = ST_LOW;
					end
				end
			end
			ST_LOW: begin
				if (texp) begin
					if (left_reg == TAP_MIN && !cmd_reg.store &&
					    !cmd_reg.keep_sel) begin
						// strobe stays low through the deselect: no save
						pins_next.select_n = 1'b1;
						tload      = 1'b1;
						tcount     = TIMER_W'(NOSAVE_WAIT_CYC);
						state_next = ST_DESEL;
					end else begin
						// rising edge moves nothing, it only rearms
						pins_next.step_n = 1'b1;
						tload      = 1'b1;
						tcount     = TIMER_W'(STEP_HIGH_CYC);
						state_next = ST_HIGH;
					end
				end
			end
			ST_HIGH: begin
				// high phase also covers the strobe-to-deselect gap
				if (texp) begin
					if (left_reg != TAP_MIN) begin
						pins_next.step_n = 1'b0;
						pos_next   = sat_step(pos_reg, pins_reg.dir_up);
						left_next  = left_reg - POS_ONE;
						tload      = 1'b1;
						tcount     = TIMER_W'(STEP_LOW_CYC);
						state_next = ST_LOW;
					end else if (cmd_reg.keep_sel) begin
						done_next  = 1'b1;
						state_next = ST_HOLD;
					end else begin
						pins_next.select_n = 1'b1;
						tload      = 1'b1;
						tcount     = TIMER_W'(STORE_HOLD);
						state_next = ST_DESEL;
					end
				end
			end
			ST_HOLD: begin
				// still selected, strobe high: more moves may follow
				if (cmd_valid_in) begin
					cmd_next = cmd_in;
					if (cmd_in.steps != TAP_MIN) begin
						pins_next.dir_up = cmd_in.dir_up;
						left_next  = cmd_in.steps;
						tload      = 1'b1;
						tcount     = TIMER_W'(DIR_TO_STEP_CYC);
						state_next = ST_SETUP;
					end else if (!cmd_in.keep_sel) begin
						// with no strobe left to hold low, leaving saves
						pins_next.select_n = 1'b1;
						tload      = 1'b1;
						tcount     = TIMER_W'(STORE_HOLD);
						state_next = ST_DESEL;
					end else begin
						done_next = 1'b1;
					end
				end
			end
			ST_DESEL: begin
				// strobe returns high while deselected, ignored there
				pins_next.step_n = 1'b1;
				if (texp) begin
					done_next  = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
				pins_next  = '{select_n: 1'b1, step_n: 1'b1, dir_up: 1'b0};
			end
		endcase
		// a full-length downward move pins the model to the bottom tap
		if (tload && state_next == ST_SETUP && !cmd_next.dir_up &&
		    cmd_next.steps >= TAP_MAX)
			known_next = 1'b1;
		ready_next = (state_next == ST_IDLE) || (state_next == ST_HOLD);
		busy_next  = !ready_next;
	end

	// registers only; pins rest deselected with strobe inactive
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= ST_PWRUP;
			pins_reg  <= '{select_n: 1'b1, step_n: 1'b1, dir_up: 1'b0};
			cmd_reg   <= '0;
			left_reg  <= '0;
			pos_reg   <= '0;
			known_reg <= 1'b0;
			ready_reg <= 1'b0;
			busy_reg  <= 1'b1;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			pins_reg  <= pins_next;
			cmd_reg   <= cmd_next;
			left_reg  <= left_next;
			pos_reg   <= pos_next;
			known_reg <= known_next;
			ready_reg <= ready_next;
			busy_reg  <= busy_next;
			done_reg  <= done_next;
		end
	end

	assign pins_out      = pins_reg;
	assign cmd_ready_out = ready_reg;
	assign busy_out      = busy_reg;
	assign done_out      = done_reg;
	assign pos_out       = pos_reg;
	assign pos_known_out = known_reg;

	// helper counters read only by the checks below
	logic [TIMER_W-1:0] lo_cnt_reg, lo_cnt_next;   // strobe low cycles
	logic [TIMER_W-1:0] hi_cnt_reg, hi_cnt_next;   // strobe high cycles
	logic [TIMER_W-1:0] off_cnt_reg, off_cnt_next; // select high cycles
	logic [TIMER_W-1:0] up_cnt_reg, up_cnt_next;   // cycles since reset
	logic               saved_reg, saved_next;     // last deselect saved

	// saturating counts of strobe low, strobe high and select high time, and of cycles since reset
	always_comb begin
		lo_cnt_next  = pins_reg.step_n ? '0 : lo_cnt_reg + TIMER_W'(1);
		hi_cnt_next  = !pins_reg.step_n ? '0 : hi_cnt_reg + TIMER_W'(1);
		off_cnt_next = !pins_reg.select_n ? '0 : off_cnt_reg + TIMER_W'(1);
		up_cnt_next  = up_cnt_reg + TIMER_W'(1);
		if (lo_cnt_reg == '1)
			lo_cnt_next = lo_cnt_reg;
		if (hi_cnt_reg == '1)
			hi_cnt_next = hi_cnt_reg;
		if (off_cnt_reg == '1)
			off_cnt_next = off_cnt_reg;
		if (up_cnt_reg == '1)
			up_cnt_next = up_cnt_reg;
		saved_next = saved_reg;
		if (!pins_reg.select_n && pins_next.select_n)
			saved_next = pins_next.step_n;
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lo_cnt_reg  <= '0;
			hi_cnt_reg  <= '0;
			off_cnt_reg <= '0;
			up_cnt_reg  <= '0;
			saved_reg   <= 1'b0;
		end else begin
			lo_cnt_reg  <= lo_cnt_next;
			hi_cnt_reg  <= hi_cnt_next;
			off_cnt_reg <= off_cnt_next;
			up_cnt_reg  <= up_cnt_next;
			saved_reg   <= saved_next;
		end
	end

	no_sel_low_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		$fell(pins_out.select_n) |-> pins_out.step_n)
		else $error("select lowered while strobe low");

	store_gap_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		$rose(pins_out.select_n) && pins_out.step_n |->
			hi_cnt_reg >= TIMER_W'(STROBE_GAP_CYC))
		else $error("strobe high too briefly before save deselect");

	reselect_hold_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		$fell(pins_out.select_n) && saved_reg |->
			off_cnt_reg >= TIMER_W'(STORE_HOLD))
		else $error("reselected too soon after a save");

	nosave_hold_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		$fell(pins_out.select_n) |->
			off_cnt_reg >= TIMER_W'(NOSTORE_HOLD_CYC))
		else $error("reselected too soon after deselect");

	dir_change_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		$changed(pins_out.dir_up) |->
			pins_out.step_n && hi_cnt_reg >= TIMER_W'(DIR_CHANGE_CYC))
		else $error("direction moved too soon after strobe rose");

	save_choice_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		$rose(pins_out.select_n) |->
			pins_out.step_n == (cmd_reg.store || cmd_reg.keep_sel ||
				$past(state_reg) == ST_HOLD))
		else $error("deselect strobe level disagrees with save request");

	power_wait_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		$fell(pins_out.select_n) |-> up_cnt_reg >= TIMER_W'(PWRUP_WAIT))
		else $error("device selected before power-up settling");

	step_model_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		$fell(pins_out.step_n) |->
			!pins_out.select_n &&
			pos_out == sat_step($past(pos_out), pins_out.dir_up))
		else $error("position model did not follow the step");

	strobe_width_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		$rose(pins_out.step_n) && !pins_out.select_n |->
			lo_cnt_reg >= TIMER_W'(STEP_LOW_CYC))
		else $error("strobe low phase too short");

	tap_range_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		pos_out <= TAP_MAX)
		else $error("position model beyond last tap");

endmodule

//--- test/pot_device_model.sv
// behavioural model of the potentiometer that the host controller drives
`timescale 1ns/1ps
module pot_device_model
	import pot_host_pkg::*;
#(
	parameter logic [POS_W-1:0] NV_INIT   = 7'h32, // first saved tap
	parameter real              STORE_GAP = 500.0, // least ns high after save
	parameter real              OVERLAP   = 500.0  // ns old tap stays closed
) (
	input  wire logic        power_in,  // rising edge is a power-up
	input  wire pot_pins_t   pins_in,   // select, strobe, direction
	output logic [POS_W-1:0] tap_out,   // wiper counter
	output logic [POS_W-1:0] nv_out,    // saved counter
	output logic [99:0]      taps_out,  // one closed switch per tap
	output int               viol_out   // host timing faults seen
);
	realtime t_rise;  // last strobe rise
	realtime t_desel; // last select rise
	logic    saved;   // last deselect stored the counter
	logic    mbb;     // old tap still closed during a move
	logic [POS_W-1:0] tap_prev; // tap that the last step left

	initial begin
		tap_out = NV_INIT;
		nv_out = NV_INIT;
		viol_out = 0;
		t_rise = 0;
		t_desel = -1.0e9;
		saved = 1'b0;
		mbb = 1'b0;
		tap_prev = NV_INIT;
	end

	// one step, held at both ends instead of wrapping
	function automatic logic [POS_W-1:0] stepped(input logic [POS_W-1:0] p,
		input logic up);
		if (up)
			return (p == TAP_MAX) ? p : p + POS_ONE;
		return (p == TAP_MIN) ? p : p - POS_ONE;
	endfunction

	// power return reloads the saved tap at once
	always @(posedge power_in) tap_out = nv_out;

	// falling strobe moves the wiper only while selected and powered;
	// the switch that is left stays closed a while (make before break)
	always @(negedge pins_in.step_n) begin
		if (power_in && !pins_in.select_n) begin
			tap_prev = tap_out;
			tap_out = stepped(tap_out, pins_in.dir_up);
			mbb = 1'b1;
			#(OVERLAP) mbb = 1'b0;
		end
	end

	always @(posedge pins_in.step_n) t_rise = $realtime;

	// direction may only change a while after the strobe rose
	always @(pins_in.dir_up) begin
		if (power_in && !pins_in.select_n && $realtime - t_rise < 100.0)
			viol_out++;
	end

	// select rise: strobe high stores, strobe low skips the store;
	// pins settling while unpowered are no deselect at all
	always @(posedge pins_in.select_n) if (power_in) begin
		t_desel = $realtime;
		saved = pins_in.step_n;
		if (pins_in.step_n) begin
			nv_out = tap_out;
			if ($realtime - t_rise < 1000.0)
				viol_out++;
		end
	end

	// reselect too soon is a fault; falling select with strobe low steps
	always @(negedge pins_in.select_n) if (power_in) begin
		if ($realtime - t_desel < (saved ? STORE_GAP : 100.0))
			viol_out++;
		if (!pins_in.step_n)
			tap_out = stepped(tap_out, pins_in.dir_up);
	end

	// decode closes one switch; the old one lingers just after a step
	always_comb begin
		taps_out = '0;
		taps_out[tap_out] = 1'b1;
		if (mbb)
			taps_out[tap_prev] = 1'b1;
	end
endmodule

//--- test/tb_top.sv
// self-checking bench for the wiper host controller against a device model
`timescale 1ns/1ps
module tb_top;
	import pot_host_pkg::*;

	localparam logic [POS_W-1:0] NV_INIT = 7'h32; // first saved tap

	logic             core_clk;  // 40 MHz bench clock
	logic             resetn;    // reset, doubles as device power
	logic             cmd_valid; // request strobe
	move_cmd_t        cmd;       // request payload
	logic             cmd_ready;
	logic             busy;
	logic             done;
	logic [POS_W-1:0] pos;
	logic             pos_known;
	pot_pins_t        pins;
	logic [POS_W-1:0] tap;       // device wiper
	logic [POS_W-1:0] nv;        // device saved tap
	logic [99:0]      taps;      // device switches
	int               viol;      // timing faults seen by the device
	int               err_count;
	int               check_count;
	int               seed;
	int               dev_exp;   // expected device tap
	int               nv_exp;    // expected saved tap
	int               pos_exp;   // expected host tap estimate
	logic             known_exp;
	logic             in_hold;   // device left selected

	pot_host_ctrl #(.STORE_HOLD(20), .PWRUP_WAIT(10)) dut_u (
		.core_clk_in  (core_clk),
		.resetn_in    (resetn),
		.cmd_valid_in (cmd_valid),
		.cmd_in       (cmd),
		.cmd_ready_out(cmd_ready),
		.busy_out     (busy),
		.done_out     (done),
		.pos_out      (pos),
		.pos_known_out(pos_known),
		.pins_out     (pins)
	);

	// store gap scaled to the shortened save hold of 20 cycles
	pot_device_model #(.NV_INIT(NV_INIT), .STORE_GAP(500.0)) dev_u (
		.power_in(resetn),
		.pins_in (pins),
		.tap_out (tap),
		.nv_out  (nv),
		.taps_out(taps),
		.viol_out(viol)
	);

	always #12.5 core_clk = ~core_clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [99:0] got, input logic [99:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got 0x%h expected 0x%h",
				$time, got, exp);
		end
	endtask

	// saturating step of the reference counters
	function automatic int sat(input int p, input logic up);
		if (up)
			return (p < int'(TAP_MAX)) ? p + 1 : p;
		return (p > 0) ? p - 1 : p;
	endfunction

	// bounded wait for the power-up recall to end
	task automatic wait_ready();
		int i;
		for (i = 0; i < 100 && cmd_ready !== 1'b1; i++)
			@(negedge core_clk);
		chk(cmd_ready, 1'b1);
	endtask

	// one move: reference update, handshake, refused pokes, checks
	task automatic run_cmd(input logic up, input logic [POS_W-1:0] n,
		input logic st, input logic kp);
		int        i;
		move_cmd_t c;
		c = {up, n, st, kp};
		for (i = 0; i < n; i++) begin
			dev_exp = sat(dev_exp, up);
			pos_exp = sat(pos_exp, up);
		end
		if (!up && n >= 7'h63)
			known_exp = 1'b1;
		if (!kp && ((st && n != 0) || (n == 0 && in_hold)))
			nv_exp = dev_exp;
		in_hold = kp;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		i = 0;
		do
			@(negedge core_clk);
		while (cmd_ready !== 1'b1 && ++i < 100);
		@(posedge core_clk);
		// a busy controller must ignore a second request
		if (n != 0) begin
			cmd <= ~c;
			repeat (2) @(posedge core_clk);
			chk(busy, 1'b1);
		end
		cmd_valid <= 1'b0;
		for (i = 0; i < 20000 && done !== 1'b1; i++)
			@(negedge core_clk);
		chk(done, 1'b1);
		chk(tap, dev_exp);
		chk(taps, 100'h1 << dev_exp);
		chk(busy, 1'b0);
		chk(nv, nv_exp);
		chk(pins.select_n, !kp);
		chk(pos, pos_exp);
		chk(pos_known, known_exp);
	endtask

	// hang guard, about 90000 cycles
	initial begin
		#2250000;
		err_count++;
		$display("unexpected at %0t: got 0x%h expected 0x%h", $time, 0, 1);
		stop_test();
	end

	initial begin : main
		int         k;
		logic [2:0] r;
		core_clk = 1'b0;
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		err_count = 0;
		check_count = 0;
		seed = 54;
		dev_exp = NV_INIT;
		nv_exp = NV_INIT;
		pos_exp = 0;
		known_exp = 1'b0;
		in_hold = 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(negedge core_clk);
		chk(pins, 3'b110);
		wait_ready();
		chk(tap, dev_exp);
		run_cmd(1'b0, 7'h63, 1'b0, 1'b0);
		run_cmd(1'b1, 7'h03, 1'b1, 1'b0);
		run_cmd(1'b1, 7'h02, 1'b0, 1'b1);
		run_cmd(1'b0, 7'h01, 1'b0, 1'b0);
		run_cmd(1'b1, 7'h78, 1'b1, 1'b0);
		run_cmd(1'b0, 7'h00, 1'b0, 1'b0);
		run_cmd(1'b0, 7'h00, 1'b1, 1'b1);
		run_cmd(1'b1, 7'h00, 1'b0, 1'b1);
		// random short moves; a final zero move leaves any hold
		for (k = 0; k < 6; k++) begin
			r = 3'($random(seed));
			run_cmd(r[0], (7'($random(seed)) & 7'h07) + 7'h01, r[1], r[2]);
		end
		run_cmd(1'b0, 7'h00, 1'b0, 1'b0);
		// power cycle: device recalls its saved tap
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		dev_exp = nv_exp;
		pos_exp = 0;
		known_exp = 1'b0;
		wait_ready();
		chk(tap, dev_exp);
		run_cmd(1'b1, 7'h01, 1'b1, 1'b0);
		chk(viol, 0);
		stop_test();
	end
endmodule
